/* verilog/lmf_regs.sv */
// Function-register bank of a 144-LED matrix driver with blink, breath, audio and done logic.
// Assumes a serial front end that turns host transactions into register strobes.
// What this block does
// - Blink-on bit lets per-LED blink bits blink; otherwise nothing blinks
// - Blink period is field value times about 0.27 s
// - Blinking LEDs are lit half and dark half of each period
// - Audio-modulation bit scales whole-matrix intensity by the audio level
// - Frame state register is read-only; writes change nothing
// - In auto play, movie end sets the movie-finished flag
// - Only reset or a frame state read clears the movie-finished flag; a set in the same cycle wins
// - Frame state low bits report the frame currently shown
// - Done pin goes low on flag set, returns high after 7 ms
// - Fade-out time is 26 ms times two to the field
// - Fade-in time is 26 ms times two to the field
// - Breath enable turns breathing on in picture and auto play only
// - Dark gap is 3.5 ms times two to the field
// - Soft power bit 0 means shutdown, 1 normal; resets to 0
// - Shutdown blanks the matrix while registers stay readable and writable
// - Gain register holds speed bit and automatic gain enable bit
// - Gain field picks 0 to 21 dB in audio modes only
// - Sampling period is field times 46 us; zero means 256
// - Sampling period steps frames only in audio frame play mode
// - Each LED has an 8-bit level giving 256 linear duty steps
`timescale 1ns/1ps
module lmf_regs
    import lmf_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYCLES = BLINK_HALF_CYC,
    parameter int unsigned FADE_STEP_CYCLES  = FADE_STEP_CYC,
    parameter int unsigned GAP_UNIT_CYCLES   = GAP_UNIT_CYC,
    parameter int unsigned SAMPLE_CYCLES     = SAMPLE_UNIT_CYC,
    parameter int unsigned DONE_LOW_CYCLES   = DONE_LOW_CYC
) (
    input  wire logic       mclk_in,
    input  wire logic       rst_n_in,
    input  wire logic       ce_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic       mode_picture_in,
    input  wire logic       mode_auto_in,
    input  wire logic       mode_audio_in,
    input  wire logic [2:0] shown_frame_in,
    input  wire logic       movie_end_in,
    input  wire logic       frame_switch_in,
    input  wire logic [7:0] audio_level_in,
    input  wire logic [7:0] led_level_in,
    input  wire logic       led_blink_bit_in,
    output logic [7:0]      reg_rdata_out,
    output logic [2:0]      bright_frame_out,
    output logic            led_drive_out,
    output logic            drivers_on_out,
    output logic            done_pin_n_out,
    output logic            sample_tick_out,
    output logic [2:0]      gain_sel_out,
    output logic            agc_on_out,
    output logic            agc_fast_out
);
    localparam logic [31:0] DONE_LAST = 32'(DONE_LOW_CYCLES - 1);

    // Register storage
    logic [7:0]  display_options;
    logic [7:0]  audio_sync_control;
    logic [7:0]  breath_fade_times;
    logic [7:0]  breath_enable_gap;
    logic [7:0]  soft_power_control;
    logic [7:0]  input_gain_control;
    logic [7:0]  audio_sample_period;
    logic        done_flag;

    // Field views
    wire         shared_intensity = display_options[SHARED_INT_BIT];
    wire         blink_on         = display_options[BLINK_ON_BIT];
    wire [2:0]   blink_period     = display_options[BLINK_PER_LSB +: 3];
    wire         audio_mod_enable = audio_sync_control[AUDIO_MOD_BIT];
    wire [2:0]   fade_out_time    = breath_fade_times[FADE_OUT_LSB +: 3];
    wire [2:0]   fade_in_time     = breath_fade_times[FADE_IN_LSB +: 3];
    wire         breath_on        = breath_enable_gap[BREATH_EN_BIT];
    wire [2:0]   dark_gap_time    = breath_enable_gap[GAP_LSB +: 3];
    wire         soft_power_on    = soft_power_control[SOFT_POWER_BIT];
    wire         gain_ctl_speed   = input_gain_control[GAIN_SPEED_BIT];
    wire         agc_enable       = input_gain_control[AGC_EN_BIT];
    wire [2:0]   input_gain_sel   = input_gain_control[GAIN_SEL_LSB +: 3];
    wire [7:0]   sample_period    = audio_sample_period;

    // Register access decode
    wire         wr_disp   = reg_wr_in && (reg_addr_in == ADDR_DISPLAY_OPT);
    wire         wr_audio  = reg_wr_in && (reg_addr_in == ADDR_AUDIO_SYNC);
    wire         wr_fade   = reg_wr_in && (reg_addr_in == ADDR_BREATH_FADE);
    wire         wr_gap    = reg_wr_in && (reg_addr_in == ADDR_BREATH_GAP);
    wire         wr_power  = reg_wr_in && (reg_addr_in == ADDR_SOFT_POWER);
    wire         wr_gain   = reg_wr_in && (reg_addr_in == ADDR_GAIN_CTL);
    wire         wr_sample = reg_wr_in && (reg_addr_in == ADDR_SAMPLE_PER);
    wire         rd_state  = reg_rd_in && (reg_addr_in == ADDR_FRAME_STATE);
    wire [7:0]   frame_state = ({7'h00, done_flag} << DONE_FLAG_BIT)
                             | ({5'h00, shown_frame_in} << FRAME_LSB);
    logic [7:0]  rd_mux;

    always_comb begin
        unique case (reg_addr_in)
            ADDR_DISPLAY_OPT: rd_mux = display_options;
            ADDR_AUDIO_SYNC:  rd_mux = audio_sync_control;
            ADDR_FRAME_STATE: rd_mux = frame_state;
            ADDR_BREATH_FADE: rd_mux = breath_fade_times;
            ADDR_BREATH_GAP:  rd_mux = breath_enable_gap;
            ADDR_SOFT_POWER:  rd_mux = soft_power_control;
            ADDR_GAIN_CTL:    rd_mux = input_gain_control;
            ADDR_SAMPLE_PER:  rd_mux = audio_sample_period;
            default:          rd_mux = REG_RESET;
        endcase
    end

    // Writable registers; frame state has no write path and power-down keeps contents
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            display_options     <= REG_RESET;
            audio_sync_control  <= REG_RESET;
            breath_fade_times   <= REG_RESET;
            breath_enable_gap   <= REG_RESET;
            soft_power_control  <= REG_RESET;
            input_gain_control  <= REG_RESET;
            audio_sample_period <= REG_RESET;
        end else if (ce_in) begin
            if (wr_disp)   display_options     <= reg_wdata_in & MASK_DISPLAY_OPT;
            if (wr_audio)  audio_sync_control  <= reg_wdata_in & MASK_AUDIO_SYNC;
            if (wr_fade)   breath_fade_times   <= reg_wdata_in & MASK_BREATH_FADE;
            if (wr_gap)    breath_enable_gap   <= reg_wdata_in & MASK_BREATH_GAP;
            if (wr_power)  soft_power_control  <= reg_wdata_in & MASK_SOFT_POWER;
            if (wr_gain)   input_gain_control  <= reg_wdata_in & MASK_GAIN_CTL;
            if (wr_sample) audio_sample_period <= reg_wdata_in & MASK_SAMPLE_PER;
        end
    end

    // Read data register
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= REG_RESET;
        end else if (ce_in && reg_rd_in) begin
            reg_rdata_out <= rd_mux;
        end
    end

    // Movie-finished flag and done pin
    wire         flag_set = movie_end_in && mode_auto_in;
    logic [31:0] done_cnt;
    wire         done_at_last = (done_cnt == DONE_LAST);

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_flag <= 1'b0;
        end else if (ce_in) begin
            done_flag <= flag_set || (done_flag && !rd_state);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_pin_n_out <= 1'b1;
            done_cnt       <= '0;
        end else if (ce_in) begin
            if (flag_set) begin
                done_pin_n_out <= 1'b0;
                done_cnt       <= '0;
            end else if (!done_pin_n_out) begin
                done_pin_n_out <= done_at_last;
                done_cnt       <= done_cnt + 32'h0000_0001;
            end
        end
    end

    // Blink: half-period tick, count blink_period ticks per half
    logic        blink_tick;
    logic [2:0]  blink_cnt;
    logic        blink_lit;
    wire         blink_run  = blink_on && (blink_period != 3'h0);
    wire         blink_wrap = (blink_cnt + ONE3) == blink_period;

    lmf_tick #(.CYCLES(BLINK_HALF_CYCLES)) u_blink_tick (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .run_in   (blink_run),
        .tick_out (blink_tick)
    );

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            blink_cnt <= 3'h0;
            blink_lit <= 1'b1;
        end else if (ce_in) begin
            if (!blink_run) begin
                blink_cnt <= 3'h0;
                blink_lit <= 1'b1;
            end else if (blink_tick) begin
                blink_cnt <= blink_wrap ? 3'h0 : blink_cnt + ONE3;
                blink_lit <= blink_wrap ? !blink_lit : blink_lit;
            end
        end
    end

    // Breathing sequencer
    lmf_breath_e br_state;
    lmf_breath_e next_br_state;
    logic [7:0]  br_level;
    logic [7:0]  br_cnt;
    logic        step_tick;
    logic        gap_tick;
    wire         br_allowed = breath_on && (mode_picture_in || mode_auto_in);
    wire         br_start   = mode_picture_in || frame_switch_in;
    wire [7:0]   out_limit  = (ONE8 << fade_out_time) - ONE8;
    wire [7:0]   in_limit   = (ONE8 << fade_in_time) - ONE8;
    wire [7:0]   gap_limit  = (ONE8 << dark_gap_time) - ONE8;
    wire         in_fade    = (br_state == BR_FADE_OUT) || (br_state == BR_FADE_IN);
    wire         in_dark    = (br_state == BR_DARK);
    wire [7:0]   cur_limit  = (br_state == BR_FADE_OUT) ? out_limit
                            : in_dark ? gap_limit : in_limit;
    wire         unit_tick  = in_dark ? gap_tick : step_tick;
    wire         unit_done  = unit_tick && (br_cnt == cur_limit);

    lmf_tick #(.CYCLES(FADE_STEP_CYCLES)) u_fade_tick (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .run_in   (in_fade),
        .tick_out (step_tick)
    );

    lmf_tick #(.CYCLES(GAP_UNIT_CYCLES)) u_gap_tick (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .run_in   (in_dark),
        .tick_out (gap_tick)
    );

    always_comb begin
        next_br_state = br_state;
        unique case (br_state)
            BR_LIT:      if (br_allowed && br_start) next_br_state = BR_FADE_OUT;
            BR_FADE_OUT: if (unit_done && br_level == LEVEL_MIN) next_br_state = BR_DARK;
            BR_DARK:     if (unit_done) next_br_state = BR_FADE_IN;
            BR_FADE_IN:  if (unit_done && br_level == LEVEL_MAX) next_br_state = BR_LIT;
        endcase
        if (!br_allowed) next_br_state = BR_LIT;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            br_state <= BR_LIT;
            br_level <= LEVEL_MAX;
            br_cnt   <= 8'h00;
        end else if (ce_in) begin
            br_state <= next_br_state;
            br_cnt   <= (unit_done || next_br_state != br_state) ? 8'h00
                      : unit_tick ? br_cnt + ONE8 : br_cnt;
            if (next_br_state == BR_LIT)
                br_level <= LEVEL_MAX;
            else if (unit_done && br_state == BR_FADE_OUT && br_level != LEVEL_MIN)
                br_level <= br_level - ONE8;
            else if (unit_done && br_state == BR_FADE_IN && br_level != LEVEL_MAX)
                br_level <= br_level + ONE8;
        end
    end

    // Audio sampling period, frame stepping in audio play only
    logic        sample_unit;
    logic [8:0]  sample_cnt;
    wire [8:0]   sample_limit = (sample_period == 8'h00) ? SAMPLE_ZERO_UNITS
                                                          : {1'b0, sample_period};
    wire         sample_wrap  = sample_unit && ((sample_cnt + ONE9) == sample_limit);

    lmf_tick #(.CYCLES(SAMPLE_CYCLES)) u_sample_tick (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .run_in   (mode_audio_in),
        .tick_out (sample_unit)
    );

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sample_cnt      <= 9'h000;
            sample_tick_out <= 1'b0;
        end else if (ce_in) begin
            if (!mode_audio_in)
                sample_cnt <= 9'h000;
            else if (sample_unit)
                sample_cnt <= sample_wrap ? 9'h000 : sample_cnt + ONE9;
            sample_tick_out <= mode_audio_in && sample_wrap;
        end
    end

    // LED duty: level scaled by audio and breath, gated by blink and power
    logic [7:0]  pwm_cnt;
    wire [8:0]   audio_mult = {1'b0, audio_level_in} + ONE9;
    wire [8:0]   br_mult    = {1'b0, br_level} + ONE9;
    wire [16:0]  audio_prod = {9'h000, led_level_in} * audio_mult;
    wire [7:0]   lvl_audio  = audio_mod_enable ? audio_prod[15:8] : led_level_in;
    wire [16:0]  br_prod    = {9'h000, lvl_audio} * br_mult;
    wire [7:0]   lvl_final  = br_prod[15:8];
    wire         blink_dark = blink_on && led_blink_bit_in && !blink_lit;
    wire         drive_next = soft_power_on && !blink_dark && (pwm_cnt < lvl_final);
    wire         audio_path = mode_audio_in || audio_mod_enable;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwm_cnt          <= 8'h00;
            led_drive_out    <= 1'b0;
            drivers_on_out   <= 1'b0;
            bright_frame_out <= FRAME_ONE;
            gain_sel_out     <= GAIN_NONE;
            agc_on_out       <= 1'b0;
            agc_fast_out     <= 1'b0;
        end else if (ce_in) begin
            pwm_cnt          <= pwm_cnt + ONE8;
            led_drive_out    <= drive_next;
            drivers_on_out   <= soft_power_on;
            bright_frame_out <= shared_intensity ? FRAME_ONE : shown_frame_in;
            gain_sel_out     <= audio_path ? input_gain_sel : GAIN_NONE;
            agc_on_out       <= audio_path && agc_enable;
            agc_fast_out     <= gain_ctl_speed;
        end
    end

endmodule : lmf_regs

/* verilog/lmf_pkg.sv */
// Constants for the LED matrix function-register bank: offsets, fields, masks, timing.
// Assumes a 200 MHz core clock; time figures are converted to cycles here.
package lmf_pkg;

    localparam int unsigned CLK_PERIOD_NS     = 5;

    // Register offsets
    localparam logic [7:0]  ADDR_DISPLAY_OPT  = 8'h05;
    localparam logic [7:0]  ADDR_AUDIO_SYNC   = 8'h06;
    localparam logic [7:0]  ADDR_FRAME_STATE  = 8'h07;
    localparam logic [7:0]  ADDR_BREATH_FADE  = 8'h08;
    localparam logic [7:0]  ADDR_BREATH_GAP   = 8'h09;
    localparam logic [7:0]  ADDR_SOFT_POWER   = 8'h0A;
    localparam logic [7:0]  ADDR_GAIN_CTL     = 8'h0B;
    localparam logic [7:0]  ADDR_SAMPLE_PER   = 8'h0C;

    // Reset value and writable-bit masks
    localparam logic [7:0]  REG_RESET         = 8'h00;
    localparam logic [7:0]  MASK_DISPLAY_OPT  = 8'h2F;
    localparam logic [7:0]  MASK_AUDIO_SYNC   = 8'h01;
    localparam logic [7:0]  MASK_BREATH_FADE  = 8'h77;
    localparam logic [7:0]  MASK_BREATH_GAP   = 8'h17;
    localparam logic [7:0]  MASK_SOFT_POWER   = 8'h01;
    localparam logic [7:0]  MASK_GAIN_CTL     = 8'h1F;
    localparam logic [7:0]  MASK_SAMPLE_PER   = 8'hFF;

    // Field positions
    localparam int unsigned SHARED_INT_BIT    = 5;
    localparam int unsigned BLINK_ON_BIT      = 3;
    localparam int unsigned BLINK_PER_LSB     = 0;
    localparam int unsigned AUDIO_MOD_BIT     = 0;
    localparam int unsigned DONE_FLAG_BIT     = 4;
    localparam int unsigned FRAME_LSB         = 0;
    localparam int unsigned FADE_OUT_LSB      = 4;
    localparam int unsigned FADE_IN_LSB       = 0;
    localparam int unsigned BREATH_EN_BIT     = 4;
    localparam int unsigned GAP_LSB           = 0;
    localparam int unsigned SOFT_POWER_BIT    = 0;
    localparam int unsigned GAIN_SPEED_BIT    = 4;
    localparam int unsigned AGC_EN_BIT        = 3;
    localparam int unsigned GAIN_SEL_LSB      = 0;

    // Levels and counts
    localparam logic [7:0]  LEVEL_MAX         = 8'hFF;
    localparam logic [7:0]  LEVEL_MIN         = 8'h00;
    localparam logic [7:0]  ONE8              = 8'h01;
    localparam logic [2:0]  ONE3              = 3'h1;
    localparam logic [8:0]  ONE9              = 9'h001;
    localparam logic [8:0]  SAMPLE_ZERO_UNITS = 9'h100;
    localparam logic [2:0]  FRAME_ONE         = 3'h0;
    localparam logic [2:0]  GAIN_NONE         = 3'h0;
    localparam int unsigned LEVEL_STEPS       = 256;

    // Times in ns, as printed
    localparam int unsigned BLINK_UNIT_NS     = 270_000_000;
    localparam int unsigned FADE_UNIT_NS      = 26_000_000;
    localparam int unsigned GAP_UNIT_NS       = 3_500_000;
    localparam int unsigned SAMPLE_UNIT_NS    = 46_000;
    localparam int unsigned DONE_LOW_NS       = 7_000_000;

    // Derived cycle counts
    localparam int unsigned BLINK_HALF_CYC    = BLINK_UNIT_NS / (2 * CLK_PERIOD_NS);
    localparam int unsigned FADE_STEP_CYC     = FADE_UNIT_NS / (CLK_PERIOD_NS * LEVEL_STEPS);
    localparam int unsigned GAP_UNIT_CYC      = GAP_UNIT_NS / CLK_PERIOD_NS;
    localparam int unsigned SAMPLE_UNIT_CYC   = SAMPLE_UNIT_NS / CLK_PERIOD_NS;
    localparam int unsigned DONE_LOW_CYC      = (DONE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        BR_LIT      = 4'b0001,
        BR_FADE_OUT = 4'b0010,
        BR_DARK     = 4'b0100,
        BR_FADE_IN  = 4'b1000
    } lmf_breath_e;

endpackage : lmf_pkg

/* verilog/lmf_tick.sv */
// Free-running tick generator: one-cycle pulse every CYCLES enabled cycles.
// Assumes the parent holds run low to restart the count from zero.
`timescale 1ns/1ps
module lmf_tick #(
    parameter int unsigned CYCLES = 4
) (
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    input  wire logic ce_in,
    input  wire logic run_in,
    output logic      tick_out
);
    localparam logic [31:0] LAST = 32'(CYCLES - 1);

    logic [31:0] cnt;
    wire         at_last = (cnt == LAST);

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt      <= '0;
            tick_out <= 1'b0;
        end else if (ce_in) begin
            cnt      <= (!run_in || at_last) ? '0 : cnt + 32'h0000_0001;
            tick_out <= run_in && at_last;
        end
    end
endmodule : lmf_tick

/* verification/lmf_regs_assertions.sv */
// Checker for the function-register bank ports.
// Assumes one clock domain; bound to every lmf_regs instance.
`timescale 1ns/1ps
module lmf_regs_chk
    import lmf_pkg::*;
#(
    parameter int unsigned DONE_LOW_CYCLES = 20
) (
    input wire logic       mclk_in,
    input wire logic       rst_n_in,
    input wire logic       ce_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic       mode_auto_in,
    input wire logic       mode_audio_in,
    input wire logic [2:0] shown_frame_in,
    input wire logic       movie_end_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       led_drive_out,
    input wire logic       drivers_on_out,
    input wire logic       done_pin_n_out,
    input wire logic       sample_tick_out
);
    wire         rd7    = ce_in && reg_rd_in && reg_addr_in == ADDR_FRAME_STATE;
    wire         go_end = ce_in && movie_end_in && mode_auto_in;
    logic [31:0] low_cnt;
    // Cycles the done pin has been low
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_cnt <= '0;
        end else if (ce_in) begin
            low_cnt <= done_pin_n_out ? '0 : low_cnt + 1;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    a_done_falls: assert property (
        go_end |=> ##[0:1] !done_pin_n_out) else $error("done pin not low");
    a_done_width: assert property (
        $rose(done_pin_n_out) |-> low_cnt == DONE_LOW_CYCLES) else $error("done width");
    a_state_frame: assert property (
        rd7 |=> reg_rdata_out[2:0] == $past(shown_frame_in) && reg_rdata_out[7:5] == 3'h0
        && !reg_rdata_out[3]) else $error("frame state bits");
    a_flag_set: assert property (
        go_end ##1 !rd7 ##1 rd7 |=> reg_rdata_out[4]) else $error("flag not set");
    a_flag_clear: assert property (
        rd7 && !movie_end_in ##1 !movie_end_in ##1 rd7 && !movie_end_in
        |=> !reg_rdata_out[4]) else $error("flag not cleared");
    a_rdata_hold: assert property (
        !(ce_in && reg_rd_in) |=> $stable(reg_rdata_out)) else $error("rdata moved");
    a_unmapped_zero: assert property (
        ce_in && reg_rd_in && (reg_addr_in < ADDR_DISPLAY_OPT || reg_addr_in > ADDR_SAMPLE_PER)
        |=> reg_rdata_out == 8'h00) else $error("unmapped read");
    a_power_write: assert property (
        ce_in && reg_wr_in && reg_addr_in == ADDR_SOFT_POWER
        |=> ##1 drivers_on_out == $past(reg_wdata_in[0], 2)) else $error("power bit");
    a_off_dark: assert property (
        !drivers_on_out && !$past(drivers_on_out) |-> !led_drive_out) else $error("lit when off");
    a_tick_audio: assert property (
        !mode_audio_in && !$past(mode_audio_in) |-> !sample_tick_out) else $error("tick");
endmodule : lmf_regs_chk

bind lmf_regs lmf_regs_chk #(.DONE_LOW_CYCLES(DONE_LOW_CYCLES)) u_lmf_regs_chk (
    .mclk_in, .rst_n_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .mode_auto_in, .mode_audio_in, .shown_frame_in, .movie_end_in, .reg_rdata_out,
    .led_drive_out, .drivers_on_out, .done_pin_n_out, .sample_tick_out);

/* verification/lmf_host_model.sv */
// Host model: turns register reads and writes into one-cycle strobes.
// Assumes the bench calls its tasks; signals change 1 ns after an edge.
`timescale 1ns/1ps
module lmf_host_model (
    input  wire logic [7:0] rdata_in,
    input  wire logic       mclk_in,
    output logic [7:0]      addr_out,
    output logic [7:0]      wdata_out,
    output logic            wr_out,
    output logic            rd_out
);
    initial begin
        addr_out  = 8'h00;
        wdata_out = 8'h00;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
    end
    // Single-byte access, address and data scrambled once strobes released
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge mclk_in);
        #1;
        addr_out  = a;
        wdata_out = d;
        wr_out    = w;
        rd_out    = !w;
        @(posedge mclk_in);
        #1;
        q         = rdata_in;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        addr_out  = ~a;
        wdata_out = ~d;
    endtask : access
endmodule : lmf_host_model

/* verification/tb_top.sv */
// Bench for the function-register bank, driven through the host model.
// Assumes shortened timing parameters and a 200 MHz clock.
`timescale 1ns/1ps
module tb_top;
    import lmf_pkg::*;
    localparam int unsigned DLOW = 20;
    localparam logic [7:0]  MSK [8] = '{MASK_DISPLAY_OPT, MASK_AUDIO_SYNC, 8'h05,
        MASK_BREATH_FADE, MASK_BREATH_GAP, MASK_SOFT_POWER, MASK_GAIN_CTL, MASK_SAMPLE_PER};
    logic       mclk_in, rst_n_in, mode_auto_in, mode_audio_in, movie_end_in, led_drive_out;
    logic       drivers_on_out, done_pin_n_out, sample_tick_out, agc_on_out, agc_fast_out;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, led_level_in, d, audio_level_in;
    logic       reg_wr_in, reg_rd_in, ce_in;
    logic [2:0] shown_frame_in, bright_frame_out, gain_sel_out;
    int         mismatches, n_tests, k;

    lmf_regs #(.BLINK_HALF_CYCLES(8), .FADE_STEP_CYCLES(2), .GAP_UNIT_CYCLES(4),
        .SAMPLE_CYCLES(4), .DONE_LOW_CYCLES(DLOW)) u_lmf_regs (
        .mclk_in, .rst_n_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .mode_picture_in(1'b0), .mode_auto_in, .mode_audio_in, .shown_frame_in,
        .movie_end_in, .frame_switch_in(1'b0), .audio_level_in, .led_level_in,
        .led_blink_bit_in(1'b0), .reg_rdata_out, .bright_frame_out, .led_drive_out,
        .drivers_on_out, .done_pin_n_out, .sample_tick_out, .gain_sel_out, .agc_on_out,
        .agc_fast_out);
    lmf_host_model u_lmf_host_model (.rdata_in(reg_rdata_out), .mclk_in,
        .addr_out(reg_addr_in), .wdata_out(reg_wdata_in), .wr_out(reg_wr_in),
        .rd_out(reg_rd_in));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        u_lmf_host_model.access(1'b1, a, v, d);
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        u_lmf_host_model.access(1'b0, a, 8'h00, d);
        chk(d, exp);
    endtask : rchk
    task automatic end_pulse(input logic auto);
        mode_auto_in = auto;
        movie_end_in = 1'b1;
        #5 movie_end_in = 1'b0;
    endtask : end_pulse
    task automatic test_done;
        $display("counts: n_tests=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    initial begin
        #50_000;
        mismatches++;
        test_done;
    end
    initial begin
        {mismatches, n_tests, mode_auto_in, mode_audio_in, movie_end_in, rst_n_in} = '0;
        shown_frame_in = 3'h5;
        audio_level_in = 8'h00;
        ce_in          = 1'b1;
        led_level_in   = 8'hFF;
        repeat (2) @(posedge mclk_in);
        #1 rst_n_in = 1'b1;
        for (k = 5; k < 13; k++) rchk(k[7:0], (k == 7) ? 8'h05 : REG_RESET);
        repeat (20) #5 chk({7'h00, led_drive_out}, 8'h00);
        for (k = 5; k < 13; k++) wr(k[7:0], 8'hFF);
        for (k = 5; k < 13; k++) rchk(k[7:0], MSK[k-5]);
        chk({7'h00, drivers_on_out}, 8'h01);
        chk({5'h00, bright_frame_out}, 8'h00);
        wr(ADDR_DISPLAY_OPT, 8'h00);
        wr(ADDR_AUDIO_SYNC, 8'h00);
        wr(ADDR_SAMPLE_PER, 8'h02);
        #10 chk({5'h00, bright_frame_out}, 8'h05);
        chk({5'h00, gain_sel_out}, 8'h00);
        mode_audio_in = 1'b1;
        #50 chk({3'h0, agc_fast_out, agc_on_out, gain_sel_out}, 8'h1F);
        k = 0;
        repeat (64) #5 k += (sample_tick_out === 1'b1);
        chk(k[7:0], 8'h08);
        mode_audio_in = 1'b0;
        #10 k = 0;
        repeat (64) #5 k += (sample_tick_out === 1'b1);
        chk(k[7:0], 8'h00);
        ce_in = 1'b0;
        wr(ADDR_SAMPLE_PER, 8'h33);
        ce_in = 1'b1;
        rchk(ADDR_SAMPLE_PER, 8'h02);
        wr(ADDR_AUDIO_SYNC, 8'h01);
        #10 chk({5'h00, gain_sel_out}, 8'h07);
        k = 0;
        repeat (64) #5 k += (led_drive_out === 1'b1);
        chk(k[7:0], 8'h00);
        audio_level_in = 8'h7F;
        #10 k = 0;
        repeat (256) #5 k += (led_drive_out === 1'b1);
        chk(k[7:0], 8'h7F);
        $display("test registers done");
        shown_frame_in = 3'h7;
        end_pulse(1'b0);
        rchk(ADDR_FRAME_STATE, 8'h07);
        end_pulse(1'b1);
        k = 0;
        while (done_pin_n_out !== 1'b0 && k < 10) #5 k++;
        k = 0;
        while (done_pin_n_out === 1'b0 && k < 100) #5 k++;
        chk(k[7:0], DLOW[7:0]);
        rchk(ADDR_FRAME_STATE, 8'h17);
        rchk(ADDR_FRAME_STATE, 8'h07);
        rchk(8'h20, 8'h00);
        end_pulse(1'b1);
        rchk(ADDR_FRAME_STATE, 8'h17);
        @(posedge mclk_in);
        #1 rst_n_in = 1'b0;
        repeat (2) @(posedge mclk_in);
        #1 rst_n_in = 1'b1;
        chk({7'h00, done_pin_n_out}, 8'h01);
        rchk(ADDR_SOFT_POWER, 8'h00);
        $display("test frame state done");
        test_done;
    end
endmodule : tb_top
